//--- hw/pmaf_pkg.sv
// Purpose: shared constants and types of the power monitor alert flag block
// Assumes: Avalon-MM register bus with 32-bit data, 16-bit registers in the low bits
// Notes: register offsets are word indices; byte address is four times the index
package pmaf_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam logic [5:0] IDX_RANGE = 6'h00;
	localparam logic [5:0] IDX_ALERT_DIAG = 6'h0B;
	localparam logic [5:0] IDX_SHUNT_OVER = 6'h0C;
	localparam logic [5:0] IDX_SHUNT_UNDER = 6'h0D;
	localparam logic [5:0] IDX_BUS_OVER = 6'h0E;
	localparam logic [5:0] IDX_BUS_UNDER = 6'h0F;
	localparam logic [5:0] IDX_TEMP_LIMIT = 6'h10;
	localparam logic [5:0] IDX_POWER_LIMIT = 6'h11;
	localparam logic [15:0] RST_ALERT_DIAG = 16'h0001;
	localparam logic [15:0] RST_SHUNT_OVER = 16'h7FFF;
	localparam logic [15:0] RST_SHUNT_UNDER = 16'h8000;
	localparam logic [15:0] RST_BUS_OVER = 16'h7FFF;
	localparam logic [15:0] RST_BUS_UNDER = 16'h0000;
	localparam logic [15:0] RST_TEMP_LIMIT = 16'h7FF0;
	localparam logic [15:0] RST_POWER_LIMIT = 16'hFFFF;
	localparam logic [1:0] RST_RANGE = 2'h0;
	localparam logic [15:0] MASK_CTRL = 16'hF000;
	localparam logic [15:0] MASK_BUS_THR = 16'h7FFF;
	localparam logic [15:0] MASK_TEMP = 16'hFFF0;
	localparam int unsigned BIT_LATCH = 15;
	localparam int unsigned BIT_CNV_ALERT = 14;
	localparam int unsigned BIT_AVG_SEL = 13;
	localparam int unsigned BIT_POLARITY = 12;
	localparam int unsigned BIT_MATH_OF = 9;
	localparam int unsigned BIT_FLAG_HI = 7;
	localparam int unsigned BIT_FLAG_LO = 2;
	localparam int unsigned BIT_CONV_RDY = 1;
	localparam int unsigned BIT_TRIM_OK = 0;
	localparam int unsigned NUM_LIMITS = 6;
	// Order of the limit flags, bit 2 upward
	typedef enum logic [2:0] {
		PMAF_LIM_POWER,
		PMAF_LIM_BUS_UNDER,
		PMAF_LIM_BUS_OVER,
		PMAF_LIM_SHUNT_UNDER,
		PMAF_LIM_SHUNT_OVER,
		PMAF_LIM_TEMP
	} pmaf_limit_t;
	typedef enum logic [1:0] {
		PMAF_BUS_IDLE,
		PMAF_BUS_ANSWER
	} pmaf_bus_state_t;
	// One measurement set handed over by the converter
	typedef struct packed {
		logic [15:0] shunt;
		logic [15:0] bus;
		logic [15:0] temp;
		logic [23:0] power;
	} pmaf_result_t;
	// Events from the conversion engine, same clock
	typedef struct packed {
		logic raw_valid;
		logic avg_valid;
		logic conv_done;
		logic conv_start;
		logic math_overflow;
		logic trim_checksum_err;
	} pmaf_event_t;
endpackage

//--- hw/pmaf_alert_flags.sv
// Purpose: limit comparators, diagnostic flags, alert pin and threshold registers
// Assumes: converter results and events arrive on clk; registers reached over Avalon-MM
// Notes: alert pin is open-drain, presented as out / output enable (enable low = drive)
`timescale 1ns/1ns
`default_nettype none
module pmaf_alert_flags
	import pmaf_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	input wire pmaf_result_t raw_result,
	input wire pmaf_result_t avg_result,
	input wire pmaf_event_t events,
	output logic alert_out,
	output logic alert_oe_n,
	output logic [1:0] shunt_range_sel
);
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	logic [15:0] ctrl_reg;
	logic [NUM_LIMITS-1:0] flag_reg;
	logic math_overflow_flag_reg;
	logic conv_ready_flag_reg;
	logic trim_checksum_ok_reg;
	logic [15:0] shunt_over_threshold_reg;
	logic [15:0] shunt_under_threshold_reg;
	logic [15:0] bus_over_threshold_reg;
	logic [15:0] bus_under_threshold_reg;
	logic [15:0] temp_limit_reg;
	logic [15:0] power_limit_reg;
	logic [1:0] range_reg;
	pmaf_bus_state_t bus_state_reg;
	logic [31:0] rdata_reg;
	logic [1:0] resp_reg;
	logic alert_out_reg;
	logic alert_oe_n_reg;

	logic alert_latch_mode;
	logic conv_ready_on_alert;
	logic alert_on_averaged_sel;
	logic alert_polarity;
	pmaf_result_t cmp_result;
	logic cmp_valid;
	logic [NUM_LIMITS-1:0] fault_now;
	logic [5:0] word_idx;
	logic bus_req;
	logic take_read;
	logic take_write;
	logic diag_read;
	logic [15:0] diag_value;
	logic alert_active;
	logic wr_ctrl;
	logic wr_range;
	logic wr_shunt_over;
	logic wr_shunt_under;
	logic wr_bus_over;
	logic wr_bus_under;
	logic wr_temp_limit;
	logic wr_power_limit;

	// Byte-lane merge, used by every writable register except the range word
	function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [31:0] wd,
			input logic [3:0] be, input logic [15:0] keep);
		logic [15:0] v;
		v = old_v;
		if (be[0]) begin
			v[7:0] = wd[7:0];
		end
		if (be[1]) begin
			v[15:8] = wd[15:8];
		end
		return v & keep;
	endfunction

	function automatic logic known_idx(input logic [5:0] idx);
		return ((idx >= IDX_ALERT_DIAG) && (idx <= IDX_POWER_LIMIT)) || (idx == IDX_RANGE);
	endfunction

	// Strobe for one register index, shared by every write and by the read-clear
	function automatic logic access_at(input logic take, input logic [5:0] idx, input logic [5:0] want);
		return take && (idx == want);
	endfunction

	// The flag field must hold one bit per limit, and the word index is cut from bits 7:2
	if (BIT_FLAG_HI - BIT_FLAG_LO + 1 != NUM_LIMITS) begin : g_chk_flags
		$error("flag field width does not match the limit count");
	end
	if (ADDR_W < 8) begin : g_chk_addr
		$error("address bus too narrow for the register map");
	end

	assign alert_latch_mode = ctrl_reg[BIT_LATCH];
	assign conv_ready_on_alert = ctrl_reg[BIT_CNV_ALERT];
	assign alert_on_averaged_sel = ctrl_reg[BIT_AVG_SEL];
	assign alert_polarity = ctrl_reg[BIT_POLARITY];

	assign word_idx = avs_address[7:2];
	assign bus_req = (bus_state_reg == PMAF_BUS_IDLE) && (avs_read || avs_write);
	assign take_read = bus_req && avs_read;
	assign take_write = bus_req && avs_write && !avs_read;
	assign diag_read = access_at(take_read, word_idx, IDX_ALERT_DIAG);
	assign wr_ctrl = access_at(take_write, word_idx, IDX_ALERT_DIAG);
	assign wr_range = access_at(take_write, word_idx, IDX_RANGE);
	assign wr_shunt_over = access_at(take_write, word_idx, IDX_SHUNT_OVER);
	assign wr_shunt_under = access_at(take_write, word_idx, IDX_SHUNT_UNDER);
	assign wr_bus_over = access_at(take_write, word_idx, IDX_BUS_OVER);
	assign wr_bus_under = access_at(take_write, word_idx, IDX_BUS_UNDER);
	assign wr_temp_limit = access_at(take_write, word_idx, IDX_TEMP_LIMIT);
	assign wr_power_limit = access_at(take_write, word_idx, IDX_POWER_LIMIT);

	// Source selection
	assign cmp_result = alert_on_averaged_sel ? avg_result : raw_result;
	assign cmp_valid = alert_on_averaged_sel ? events.avg_valid : events.raw_valid;

	// Signed compare for shunt and temperature: a negative over threshold is below zero, so zero trips
	assign fault_now[PMAF_LIM_TEMP] = $signed(cmp_result.temp & MASK_TEMP) > $signed(temp_limit_reg);
	assign fault_now[PMAF_LIM_SHUNT_OVER] = $signed(cmp_result.shunt) > $signed(shunt_over_threshold_reg);
	assign fault_now[PMAF_LIM_SHUNT_UNDER] = $signed(cmp_result.shunt) < $signed(shunt_under_threshold_reg);
	assign fault_now[PMAF_LIM_BUS_OVER] = cmp_result.bus > bus_over_threshold_reg;
	assign fault_now[PMAF_LIM_BUS_UNDER] = cmp_result.bus < bus_under_threshold_reg;
	// Power limit counts in steps of 256 power LSBs
	assign fault_now[PMAF_LIM_POWER] = cmp_result.power[23:8] > power_limit_reg;

	always_comb begin
		diag_value = 16'h0000;
		diag_value[15:12] = ctrl_reg[15:12];
		diag_value[BIT_MATH_OF] = math_overflow_flag_reg;
		diag_value[BIT_FLAG_HI:BIT_FLAG_LO] = flag_reg;
		diag_value[BIT_CONV_RDY] = conv_ready_flag_reg;
		diag_value[BIT_TRIM_OK] = trim_checksum_ok_reg;
	end

	// Configuration bits of the diagnostic register
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_reg <= RST_ALERT_DIAG & MASK_CTRL;
		end else if (wr_ctrl) begin
			ctrl_reg <= lane_merge(ctrl_reg, avs_writedata, avs_byteenable, MASK_CTRL);
		end
	end

	// Range select kept in a word of its own at index 0
	always_ff @(posedge clk) begin
		if (srst) begin
			range_reg <= RST_RANGE;
		end else if (wr_range) begin
			if (avs_byteenable[0]) begin
				range_reg <= avs_writedata[1:0];
			end
		end
	end

	// Limit flags: transparent mode follows each new result, latch mode holds until read.
	// Set beats the read-clear so an event in the read cycle is not lost.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_LIMITS; gi++) begin : g_limit
			always_ff @(posedge clk) begin
				if (srst) begin
					flag_reg[gi] <= 1'b0;
				end else if (alert_latch_mode) begin
					if (cmp_valid && fault_now[gi]) begin
						flag_reg[gi] <= 1'b1;
					end else if (diag_read) begin
						flag_reg[gi] <= 1'b0;
					end
				end else if (cmp_valid) begin
					flag_reg[gi] <= fault_now[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (srst) begin
			math_overflow_flag_reg <= 1'b0;
		end else if (events.math_overflow) begin
			math_overflow_flag_reg <= 1'b1;
		end else if (events.conv_start) begin
			math_overflow_flag_reg <= 1'b0;
		end
	end

	// Conversion ready: both modes drop it when the next conversion starts; latch mode also drops it on a read
	always_ff @(posedge clk) begin
		if (srst) begin
			conv_ready_flag_reg <= 1'b0;
		end else if (events.conv_done) begin
			conv_ready_flag_reg <= 1'b1;
		end else if (events.conv_start || (alert_latch_mode && diag_read)) begin
			conv_ready_flag_reg <= 1'b0;
		end
	end

	// Checksum status only ever falls; a new reset restores it
	always_ff @(posedge clk) begin
		if (srst) begin
			trim_checksum_ok_reg <= RST_ALERT_DIAG[BIT_TRIM_OK];
		end else if (events.trim_checksum_err) begin
			trim_checksum_ok_reg <= 1'b0;
		end
	end

	// Threshold registers, one process each; bus thresholds keep bit 15 at zero
	always_ff @(posedge clk) begin
		if (srst) begin
			shunt_over_threshold_reg <= RST_SHUNT_OVER;
		end else if (wr_shunt_over) begin
			shunt_over_threshold_reg <= lane_merge(shunt_over_threshold_reg, avs_writedata, avs_byteenable,
				16'hFFFF);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			shunt_under_threshold_reg <= RST_SHUNT_UNDER;
		end else if (wr_shunt_under) begin
			shunt_under_threshold_reg <= lane_merge(shunt_under_threshold_reg, avs_writedata, avs_byteenable,
				16'hFFFF);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			bus_over_threshold_reg <= RST_BUS_OVER;
		end else if (wr_bus_over) begin
			bus_over_threshold_reg <= lane_merge(bus_over_threshold_reg, avs_writedata, avs_byteenable,
				MASK_BUS_THR);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			bus_under_threshold_reg <= RST_BUS_UNDER;
		end else if (wr_bus_under) begin
			bus_under_threshold_reg <= lane_merge(bus_under_threshold_reg, avs_writedata, avs_byteenable,
				MASK_BUS_THR);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			temp_limit_reg <= RST_TEMP_LIMIT;
		end else if (wr_temp_limit) begin
			temp_limit_reg <= lane_merge(temp_limit_reg, avs_writedata, avs_byteenable, MASK_TEMP);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			power_limit_reg <= RST_POWER_LIMIT;
		end else if (wr_power_limit) begin
			power_limit_reg <= lane_merge(power_limit_reg, avs_writedata, avs_byteenable, 16'hFFFF);
		end
	end

	// Bus slave: one wait cycle, answer on the second edge. The single wait state
	// lets the read-clear of the flags land after the value was captured.
	always_ff @(posedge clk) begin
		if (srst) begin
			bus_state_reg <= PMAF_BUS_IDLE;
		end else begin
			case (bus_state_reg)
				PMAF_BUS_IDLE: begin
					if (bus_req) begin
						bus_state_reg <= PMAF_BUS_ANSWER;
					end
				end
				PMAF_BUS_ANSWER: begin
					bus_state_reg <= PMAF_BUS_IDLE;
				end
				default: begin
					bus_state_reg <= PMAF_BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !(bus_state_reg == PMAF_BUS_IDLE && (avs_read || avs_write));
		end
	end

	// Unmapped words answer with a decode error and zero data; writes to them are dropped
	always_ff @(posedge clk) begin
		if (srst) begin
			resp_reg <= RESP_OK;
		end else if (bus_req) begin
			resp_reg <= known_idx(word_idx) ? RESP_OK : RESP_DECERR;
		end
	end

	// Read data captured at the taking edge, before the read-clear lands
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (bus_req) begin
			rdata_reg <= 32'h0000_0000;
			if (take_read) begin
				case (word_idx)
					IDX_RANGE: rdata_reg <= {30'h0, range_reg};
					IDX_ALERT_DIAG: rdata_reg <= {16'h0000, diag_value};
					IDX_SHUNT_OVER: rdata_reg <= {16'h0000, shunt_over_threshold_reg};
					IDX_SHUNT_UNDER: rdata_reg <= {16'h0000, shunt_under_threshold_reg};
					IDX_BUS_OVER: rdata_reg <= {16'h0000, bus_over_threshold_reg};
					IDX_BUS_UNDER: rdata_reg <= {16'h0000, bus_under_threshold_reg};
					IDX_TEMP_LIMIT: rdata_reg <= {16'h0000, temp_limit_reg};
					IDX_POWER_LIMIT: rdata_reg <= {16'h0000, power_limit_reg};
					default: rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign avs_readdata = rdata_reg;
	assign avs_response = resp_reg;

	// Alert pin: open-drain, so only the active level is driven
	assign alert_active = (|flag_reg) || (conv_ready_on_alert && conv_ready_flag_reg);

	// Level follows polarity alone; only the enable carries the fault state
	always_ff @(posedge clk) begin
		if (srst) begin
			alert_out_reg <= 1'b0;
		end else begin
			alert_out_reg <= alert_polarity;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			alert_oe_n_reg <= 1'b1;
		end else begin
			alert_oe_n_reg <= !alert_active;
		end
	end

	assign alert_out = alert_out_reg;
	assign alert_oe_n = alert_oe_n_reg;
	assign shunt_range_sel = range_reg;
endmodule // pmaf_alert_flags
`default_nettype wire

//--- tb/pmaf_alert_flags_props.sv
// Purpose: port checks of the alert flag block
// Assumes: one clock, srst synchronous active high
// Notes: sticky status bits are mirrored in helper flops
`timescale 1ns/1ns
`default_nettype none
module pmaf_alert_flags_props
	import pmaf_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [1:0] avs_response,
	input wire pmaf_event_t events,
	input wire logic alert_oe_n
);
	logic mof_reg;
	logic trim_reg;
	logic cause;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	assign cause = events.raw_valid || events.avg_valid || events.conv_done || avs_write;
	always_ff @(posedge clk) begin
		if (srst) mof_reg <= 1'b0;
		else if (events.math_overflow) mof_reg <= 1'b1;
		else if (events.conv_start) mof_reg <= 1'b0;
	end
	always_ff @(posedge clk) begin
		if (srst) trim_reg <= 1'b1;
		else if (events.trim_checksum_err) trim_reg <= 1'b0;
	end
	sequence req_taken;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence diag_ans;
		!avs_waitrequest && avs_read && avs_address[7:2] == IDX_ALERT_DIAG;
	endsequence
	wait_one_a: assert property (req_taken |=> !avs_waitrequest)
		else $error("late bus answer");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("long bus answer");
	diag_resv_a: assert property (diag_ans |-> avs_readdata[11:10] == 2'h0 && !avs_readdata[8])
		else $error("reserved bits set");
	bus_top_a: assert property (
		!avs_waitrequest && avs_read && avs_address[7:2] == IDX_BUS_OVER |-> !avs_readdata[15])
		else $error("bus threshold top bit set");
	unmapped_err_a: assert property (
		!avs_waitrequest && avs_read && avs_address[7:2] inside {[6'h01:6'h0A], [6'h12:6'h3F]}
		|-> avs_response == 2'h3 && avs_readdata == 32'h00000000)
		else $error("unmapped read accepted");
	math_overflow_flag_hold_a: assert property (diag_ans |-> avs_readdata[9] == $past(mof_reg))
		else $error("overflow bit wrong");
	trim_ok_a: assert property (diag_ans |-> avs_readdata[0] == $past(trim_reg))
		else $error("trim status wrong");
	alert_cause_a: assert property ($fell(alert_oe_n) |-> $past(cause, 2))
		else $error("alert without cause");
endmodule // pmaf_alert_flags_props
`default_nettype wire

//--- tb/pmaf_host_pin.sv
// Purpose: host view of the open-drain alert line
// Assumes: board pull-up on the line
// Notes: host only listens, never drives
`timescale 1ns/1ns
`default_nettype none
module pmaf_host_pin (
	input wire logic alert_out,
	input wire logic alert_oe_n,
	output logic alert_line
);
	// Released line goes to the pull-up, not to the last driven level
	assign alert_line = alert_oe_n ? 1'b1 : alert_out;
endmodule // pmaf_host_pin
`default_nettype wire

//--- tb/pmaf_alert_flags_tb.sv
// Purpose: directed register and event tests of the alert flag block
// Assumes: one wait cycle per transfer, one-clock event pulses
// Notes: thresholds chosen so each vector trips a known flag set
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module pmaf_alert_flags_tb
	import pmaf_pkg::*;
;
	localparam pmaf_event_t EV_RAW = 6'h20, EV_AVG = 6'h10, EV_DONE = 6'h08;
	localparam pmaf_event_t EV_START = 6'h04, EV_MOF = 6'h02, EV_TRIM = 6'h01;
	localparam pmaf_result_t HI = {16'h0100, 16'h0200, 16'h0200, 24'h002000};
	localparam pmaf_result_t LO = {16'hFF00, 16'h0010, 16'h0000, 24'h000000};
	localparam pmaf_result_t MID = {16'h0000, 16'h00C0, 16'h0000, 24'h000000};
	logic clk, srst, avs_read, avs_write, avs_waitrequest, alert_out, alert_oe_n, alert_line;
	logic [ADDR_W-1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdv;
	logic [3:0] avs_byteenable;
	logic [1:0] avs_response, rsp, range_sel;
	pmaf_result_t raw_result, avg_result;
	pmaf_event_t events;
	int errors, checked;
	pmaf_alert_flags dut (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.raw_result(raw_result), .avg_result(avg_result), .events(events), .alert_out(alert_out),
		.alert_oe_n(alert_oe_n), .shunt_range_sel(range_sel));
	pmaf_host_pin host (.alert_out(alert_out), .alert_oe_n(alert_oe_n), .alert_line(alert_line));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// An edge passes first so a released request is never raised in the same step
	task automatic acc(input logic w, input logic [5:0] idx, input logic [15:0] d);
		int n;
		@(posedge clk);
		avs_address <= {idx, 2'h0};
		avs_writedata <= {16'h0000, d};
		avs_write <= w;
		avs_read <= !w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest && n < 20);
		if (avs_waitrequest) begin
			errors++;
			$display("BAD %0t bus hang", $time);
			wrap_up();
		end
		rdv = avs_readdata;
		rsp = avs_response;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rc(input logic [5:0] idx, input logic [15:0] e);
		acc(1'b0, idx, 16'h0000);
		`CHK(rdv, {16'h0000, e})
	endtask
	task automatic dg(input logic [15:0] e);
		rc(IDX_ALERT_DIAG, e);
	endtask
	task automatic cf(input logic [15:0] d);
		acc(1'b1, IDX_ALERT_DIAG, d);
	endtask
	task automatic pulse(input pmaf_event_t e, input pmaf_result_t r);
		@(posedge clk);
		raw_result <= r;
		avg_result <= r;
		events <= e;
		@(posedge clk);
		events <= '0;
		@(posedge clk);
	endtask
	task automatic al(input logic oe_n, input logic line);
		@(negedge clk);
		`CHK(alert_oe_n, oe_n)
		`CHK(alert_line, line)
	endtask
	initial begin
		errors = 0;
		checked = 0;
		srst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = '0;
		avs_writedata = '0;
		avs_byteenable = 4'hF;
		raw_result = '0;
		avg_result = '0;
		events = '0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rc(IDX_SHUNT_OVER, 16'h7FFF);
		rc(IDX_SHUNT_UNDER, 16'h8000);
		rc(IDX_BUS_OVER, 16'h7FFF);
		dg(16'h0001);
		$display("t1 done");
		acc(1'b1, IDX_SHUNT_OVER, 16'h8123);
		rc(IDX_SHUNT_OVER, 16'h8123);
		acc(1'b1, IDX_SHUNT_UNDER, 16'h1234);
		rc(IDX_SHUNT_UNDER, 16'h1234);
		avs_byteenable <= 4'h2;
		acc(1'b1, IDX_SHUNT_UNDER, 16'hABCD);
		avs_byteenable <= 4'hF;
		rc(IDX_SHUNT_UNDER, 16'hAB34);
		acc(1'b1, IDX_BUS_OVER, 16'hFFFF);
		rc(IDX_BUS_OVER, 16'h7FFF);
		cf(16'hFFFF);
		dg(16'hF001);
		cf(16'h0000);
		acc(1'b0, 6'h01, 16'h0000);
		`CHK(rsp, 2'h3)
		acc(1'b1, IDX_RANGE, 16'h0003);
		`CHK(range_sel, 2'h3)
		$display("t2 done");
		acc(1'b1, IDX_SHUNT_OVER, 16'h0080);
		acc(1'b1, IDX_SHUNT_UNDER, 16'hFF80);
		acc(1'b1, IDX_BUS_OVER, 16'h0100);
		acc(1'b1, IDX_BUS_UNDER, 16'h0080);
		acc(1'b1, IDX_TEMP_LIMIT, 16'h0100);
		acc(1'b1, IDX_POWER_LIMIT, 16'h0010);
		pulse(EV_RAW, HI);
		al(1'b0, 1'b0);
		dg(16'h00D5);
		pulse(EV_RAW, LO);
		dg(16'h0029);
		pulse(EV_RAW, MID);
		al(1'b1, 1'b1);
		pulse(EV_AVG, HI);
		dg(16'h0001);
		cf(16'h2000);
		pulse(EV_RAW, HI);
		dg(16'h2001);
		pulse(EV_AVG, HI);
		dg(16'h20D5);
		cf(16'h1000);
		al(1'b0, 1'b1);
		pulse(EV_RAW, MID);
		al(1'b1, 1'b1);
		$display("t3 done");
		cf(16'h0000);
		acc(1'b1, IDX_SHUNT_OVER, 16'hFFF0);
		pulse(EV_RAW, MID);
		dg(16'h0041);
		acc(1'b1, IDX_SHUNT_OVER, 16'h0080);
		$display("t4 done");
		cf(16'h8000);
		pulse(EV_RAW, HI);
		pulse(EV_RAW, MID);
		dg(16'h80D5);
		al(1'b1, 1'b1);
		dg(16'h8001);
		$display("t5 done");
		pulse(EV_DONE, MID);
		dg(16'h8003);
		dg(16'h8001);
		pulse(EV_DONE, MID);
		pulse(EV_START, MID);
		dg(16'h8001);
		cf(16'hC000);
		pulse(EV_DONE, MID);
		al(1'b0, 1'b0);
		dg(16'hC003);
		al(1'b1, 1'b1);
		cf(16'h0000);
		pulse(EV_DONE, MID);
		dg(16'h0003);
		dg(16'h0003);
		pulse(EV_START, MID);
		$display("t6 done");
		pulse(EV_MOF, MID);
		dg(16'h0201);
		dg(16'h0201);
		pulse(EV_START, MID);
		dg(16'h0001);
		pulse(EV_TRIM, MID);
		dg(16'h0000);
		$display("t7 done");
		wrap_up();
	end
endmodule // pmaf_alert_flags_tb
bind pmaf_alert_flags pmaf_alert_flags_props u_props (.clk(clk), .srst(srst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.avs_response(avs_response), .events(events), .alert_oe_n(alert_oe_n));
`default_nettype wire
